// ===== rtl/txc_pkg.sv
// constants, types and helpers for the transmit command decoder
// assumes one clock domain and 32-bit words already assembled from the host bus
package txc_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [31:0] REG_INT_STS = 32'h0000_0000;
  localparam logic [31:0] REG_INT_EN = 32'h0000_0004;
  localparam logic [31:0] REG_INT_CLR = 32'h0000_0008;
  localparam logic [31:0] REG_DEC_STATE = 32'h0000_000c;
  localparam int STS_DONE = 0;
  localparam int STS_ERR = 1;
  localparam logic [1:0] INT_STS_RST = 2'h0;
  localparam logic [1:0] INT_EN_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // first command word fields
  localparam int CA_IOC = 31;
  localparam int CA_ALIGN_LO = 24;
  localparam int CA_OFF_LO = 16;
  localparam int CA_FIRST = 13;
  localparam int CA_LAST = 12;
  localparam int CA_SIZE_LO = 0;
  // second command word: packet length
  localparam int CB_LEN_LO = 0;

  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam logic [5:0] ALIGN_4_BYTES = 6'h04;
  localparam logic [5:0] ALIGN_16_BYTES = 6'h10;
  localparam logic [5:0] ALIGN_32_BYTES = 6'h20;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    S_CMD_A = 4'h1,
    S_CMD_B = 4'h2,
    S_DATA = 4'h4,
    S_PAD = 4'h8
  } txc_state_e;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } txc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } txc_axi_rsp_s;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } txc_word_s;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
    logic [3:0] be;
    logic buf_end;
    logic last_seg;
  } txc_beat_s;

  // ==========================================================
  // bytes rounded up to a power-of-two unit, result in 32-bit words
  function automatic logic [9:0] round_up_words(input logic [11:0] nbytes,
                                                input logic [5:0] unit);
    logic [12:0] m;
    logic [12:0] r;
    m = {7'h00, unit} - 13'h0001;
    r = ({1'b0, nbytes} + m) & ~m;
    return r[11:2];
  endfunction

endpackage

// ===== rtl/txc_pad_calc.sv
// word counts of one buffer: words holding data and words after end alignment
// assumes offset and size come straight from the first command word
`timescale 1ns/1ps
module txc_pad_calc (
  input wire logic [4:0] off,
  input wire logic [10:0] size,
  input wire logic [1:0] align,
  output logic [9:0] data_words,
  output logic [9:0] total_words,
  output logic bad_align
);
  import txc_pkg::*;

  logic [11:0] nbytes;
  logic [5:0] unit;

  // ==========================================================
  // alignment decode
  always_comb begin
    nbytes = {7'h00, off} + {1'b0, size};
    bad_align = 1'b0;
    case (align)
      ALIGN_4: unit = ALIGN_4_BYTES; // [R04]
      ALIGN_16: unit = ALIGN_16_BYTES; // [R04]
      ALIGN_32: unit = ALIGN_32_BYTES; // [R04]
      default: begin
        // reserved code: fall back to word alignment and report it
        unit = ALIGN_4_BYTES;
        bad_align = 1'b1; // [R04]
      end
    endcase
    data_words = round_up_words(nbytes, ALIGN_4_BYTES); // [R09]
    total_words = round_up_words(nbytes, unit); // [R12]
  end

endmodule

// ===== rtl/txc_decoder.sv
// transmit command decoder: parses both command words, strips offset and pad
// assumes host words arrive as 32-bit units in write order, one clock domain
//
// What this block and its host do
// [R01] completion request raises done after whole buffer
// [R02] done flag can drive interrupt output
// [R03] host writes zeros to reserved bits
// [R04] alignment code: 4, 16, 32 bytes, 11 reserved
// [R05] host pads buffer to chosen end alignment
// [R06] padding words are discarded, never sent
// [R07] five-bit start offset, zero to 31 bytes
// [R08] bytes before start offset are dropped
// [R09] size counts payload bytes only, locates padding
// [R10] summed sizes checked against packet length
// [R11] host order: command A, command B, data
// [R12] pad word count from size, offset, alignment
`timescale 1ns/1ps
module txc_decoder (
  input wire logic mclk,
  input wire logic rst,
  input wire txc_pkg::txc_axi_req_s axi_req,
  output txc_pkg::txc_axi_rsp_s axi_rsp,
  input wire txc_pkg::txc_word_s host_word,
  output logic host_ready,
  output txc_pkg::txc_beat_s mac_beat,
  input wire logic mac_ready,
  output logic irq
);
  import txc_pkg::*;

  typedef struct packed {
    txc_state_e st;
    logic ioc;
    logic first_seg;
    logic last_seg;
    logic [1:0] align;
    logic [4:0] off;
    logic [10:0] size;
    logic [10:0] pkt_len;
    logic [11:0] sum;
    logic [9:0] data_words;
    logic [9:0] words_left;
    logic [9:0] word_idx;
    txc_beat_s out;
    logic [1:0] sts;
    logic [1:0] en;
    logic aw_got;
    logic [31:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } txc_regs_s;

  txc_regs_s r;
  txc_regs_s next_r;
  logic [9:0] calc_dw;
  logic [9:0] calc_tw;
  logic calc_bad;
  logic take;
  logic [1:0] set;
  logic [1:0] clr;
  logic [11:0] new_sum;
  logic [3:0] be;

  // ==========================================================
  // byte lanes of one word that lie inside [off, off+size)
  function automatic logic [3:0] byte_en(input logic [9:0] idx, input logic [4:0] off,
                                         input logic [10:0] size);
    logic [11:0] pos;
    logic [11:0] stop;
    byte_en = 4'h0;
    stop = {7'h00, off} + {1'b0, size};
    for (int j = 0; j < 4; j++) begin
      pos = {idx, 2'b00} + 12'(j);
      byte_en[j] = (pos >= {7'h00, off}) && (pos < stop); // [R07] [R08]
    end
  endfunction

  // ==========================================================
  // pad arithmetic
  txc_pad_calc u_calc (
    .off(r.off),
    .size(r.size),
    .align(r.align),
    .data_words(calc_dw),
    .total_words(calc_tw),
    .bad_align(calc_bad)
  );

  // ==========================================================
  // ports
  // one output stage: a data word is taken only when the stage is free or draining; command and pad words always are
  always_comb begin
    case (r.st)
      S_DATA: host_ready = !r.out.valid || mac_ready;
      S_CMD_A, S_CMD_B, S_PAD: host_ready = 1'b1;
      default: host_ready = 1'b0;
    endcase
  end
  assign take = host_word.valid && host_ready;
  assign mac_beat = r.out;
  assign irq = |(r.sts & r.en); // [R02]
  assign axi_rsp.awready = !r.aw_got && !r.bvalid;
  assign axi_rsp.wready = !r.w_got && !r.bvalid;
  assign axi_rsp.bvalid = r.bvalid;
  assign axi_rsp.bresp = r.bresp;
  assign axi_rsp.arready = !r.rvalid;
  assign axi_rsp.rvalid = r.rvalid;
  assign axi_rsp.rdata = r.rdata;
  assign axi_rsp.rresp = r.rresp;

  // ==========================================================
  // next state
  always_comb begin
    next_r = r;
    set = 2'h0;
    clr = 2'h0;
    new_sum = r.first_seg ? {1'b0, r.size} : r.sum + {1'b0, r.size}; // [R10]
    be = byte_en(r.word_idx, r.off, r.size);
    if (r.out.valid && mac_ready) begin
      next_r.out.valid = 1'b0;
    end
    case (r.st)
      S_CMD_A: begin
        if (take) begin // [R11]
          // reserved bits 30:26 and 23:21 are not looked at
          next_r.ioc = host_word.data[CA_IOC]; // [R03] [R01]
          next_r.align = host_word.data[CA_ALIGN_LO +: 2]; // [R04]
          next_r.off = host_word.data[CA_OFF_LO +: 5]; // [R07]
          next_r.first_seg = host_word.data[CA_FIRST];
          next_r.last_seg = host_word.data[CA_LAST];
          next_r.size = host_word.data[CA_SIZE_LO +: 11]; // [R09]
          next_r.st = S_CMD_B;
        end
      end
      S_CMD_B: begin
        if (take) begin // [R11]
          next_r.pkt_len = host_word.data[CB_LEN_LO +: 11];
          next_r.sum = new_sum; // [R10]
          if (r.last_seg && (new_sum != {1'b0, host_word.data[CB_LEN_LO +: 11]})) begin
            set[STS_ERR] = 1'b1; // [R10]
          end
          if (calc_bad) begin
            set[STS_ERR] = 1'b1; // [R04]
          end
          next_r.data_words = calc_dw; // [R12]
          next_r.words_left = calc_tw; // [R12]
          next_r.word_idx = 10'h000;
          if (calc_tw == 10'h000) begin
            next_r.st = S_CMD_A;
            set[STS_DONE] = r.ioc; // [R01]
          end else if (calc_dw == 10'h000) begin
            next_r.st = S_PAD;
          end else begin
            next_r.st = S_DATA;
          end
        end
      end
      S_DATA: begin
        if (take) begin
          // words holding only offset bytes are swallowed
          if (be != 4'h0) begin // [R08]
            next_r.out.valid = 1'b1;
            next_r.out.data = host_word.data;
            next_r.out.be = be;
            next_r.out.buf_end = (r.word_idx == r.data_words - 10'h001);
            next_r.out.last_seg = r.last_seg;
          end
          next_r.word_idx = r.word_idx + 10'h001;
          next_r.words_left = r.words_left - 10'h001;
          if (r.words_left == 10'h001) begin
            next_r.st = S_CMD_A;
            set[STS_DONE] = r.ioc; // [R01]
          end else if (r.word_idx + 10'h001 == r.data_words) begin
            next_r.st = S_PAD; // [R09]
          end
        end
      end
      S_PAD: begin
        if (take) begin
          // host alignment words, dropped here
          next_r.words_left = r.words_left - 10'h001; // [R05] [R06]
          if (r.words_left == 10'h001) begin
            next_r.st = S_CMD_A;
            set[STS_DONE] = r.ioc; // [R01]
          end
        end
      end
      default: next_r.st = S_CMD_A;
    endcase

    // register bus: address and data may come in either order
    if (axi_req.awvalid && !r.aw_got && !r.bvalid) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !r.w_got && !r.bvalid) begin
      next_r.w_got = 1'b1;
      next_r.wdata = axi_req.wdata;
      next_r.wstrb = axi_req.wstrb;
    end
    if (r.aw_got && r.w_got) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      case (r.awaddr)
        REG_INT_EN: begin
          if (r.wstrb[0]) begin
            next_r.en = r.wdata[1:0]; // [R02]
          end
        end
        REG_INT_CLR: begin
          if (r.wstrb[0]) begin
            clr = r.wdata[1:0];
          end
        end
        REG_INT_STS, REG_DEC_STATE: next_r.bresp = RESP_OKAY;
        default: next_r.bresp = RESP_SLVERR;
      endcase
    end
    if (r.bvalid && axi_req.bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.rvalid && axi_req.rready) begin
      next_r.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      case (axi_req.araddr)
        REG_INT_STS: next_r.rdata = {30'h0, r.sts};
        REG_INT_EN: next_r.rdata = {30'h0, r.en};
        REG_INT_CLR: next_r.rdata = 32'h0;
        REG_DEC_STATE: next_r.rdata = {4'h0, r.sum, 2'h0, r.words_left, r.st};
        default: begin
          next_r.rdata = 32'h0;
          next_r.rresp = RESP_SLVERR;
        end
      endcase
    end
    // a new event outlives a clear in the same cycle
    next_r.sts = (r.sts & ~clr) | set; // [R01] [R10]
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.st <= S_CMD_A;
      r.sts <= INT_STS_RST;
      r.en <= INT_EN_RST;
    end else begin
      r <= next_r;
    end
  end

endmodule

// ===== tb/txc_decoder_asserts.sv
// port checker for the transmit command decoder
// assumes one mclk domain; bound below
`timescale 1ns/1ps
module txc_decoder_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire txc_pkg::txc_axi_req_s axi_req,
  input wire txc_pkg::txc_axi_rsp_s axi_rsp,
  input wire txc_pkg::txc_word_s host_word,
  input wire logic host_ready,
  input wire txc_pkg::txc_beat_s mac_beat,
  input wire logic mac_ready,
  input wire logic irq
);
  import txc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================
  // beat stream
  a_beat_hold: assert property (mac_beat.valid && !mac_ready |=> $stable(mac_beat))
    else $error("beat moved while stalled");
  a_beat_cause: assert property ($rose(mac_beat.valid) |-> $past(host_word.valid && host_ready))
    else $error("beat without word");
  a_beat_lanes: assert property (mac_beat.valid |-> mac_beat.be != 4'h0)
    else $error("empty beat");
  a_pad_quiet: assert property (mac_beat.valid && mac_ready && mac_beat.buf_end |=> !mac_beat.valid)
    else $error("beat after buffer end");
  // ==========================================
  // register bus
  a_rd_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read not answered");
  a_rd_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  a_wr_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##2 axi_rsp.bvalid)
    else $error("write not answered");
  a_bad_read: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr > REG_DEC_STATE
    |=> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
    else $error("unmapped read accepted");
endmodule
bind txc_decoder txc_decoder_asserts u_chk (.mclk(mclk), .rst(rst), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .host_word(host_word), .host_ready(host_ready), .mac_beat(mac_beat),
  .mac_ready(mac_ready), .irq(irq));

// ===== tb/txc_host_model.sv
// host model: command words, payload, pad words
// assumes byte k of a buffer holds value k
`timescale 1ns/1ps
module txc_host_model (
  input wire logic mclk,
  input wire logic host_ready,
  output txc_pkg::txc_word_s host_word
);
  import txc_pkg::*;
  initial host_word = '0;
  task automatic put(input logic [31:0] d);
    host_word.data <= d;
    host_word.valid <= 1'b1;
    do @(posedge mclk); while (host_ready !== 1'b1);
  endtask
  // ==========================================
  // one buffer
  task automatic send_buf(input logic ioc, input logic [1:0] al, input logic [4:0] off,
      input logic [10:0] sz, input logic fs, input logic ls, input logic [10:0] len);
    int n;
    int tot;
    n = (off + sz + 3) / 4;
    tot = al == 2'h2 ? (off + sz + 31) / 32 * 8 : al == 2'h1 ? (off + sz + 15) / 16 * 4 : n;
    @(posedge mclk);
    put({ioc, 5'h00, al, 3'h0, off, 2'h0, fs, ls, 1'b0, sz});
    put({21'h000000, len});
    for (int w = 0; w < tot; w++)
      put(w < n ? {8'(4*w+3), 8'(4*w+2), 8'(4*w+1), 8'(4*w)} : 32'hc3c3_3c3c);
    host_word.valid <= 1'b0;
    // released data flips so a stale word never looks valid
    host_word.data <= ~host_word.data;
  endtask
endmodule

// ===== tb/tb_top.sv
// bench for the transmit command decoder
// assumes host model on the word side; bench is bus master and sink
`timescale 1ns/1ps
module tb_top;
  import txc_pkg::*;
  logic mclk;
  logic rst;
  txc_axi_req_s axi_req;
  txc_axi_rsp_s axi_rsp;
  txc_word_s host_word;
  logic host_ready;
  txc_beat_s mac_beat;
  logic mac_ready = 1'b0;
  logic irq;
  int n_fail;
  int checked;
  txc_beat_s exp_q[$];
  txc_beat_s eb;
  txc_decoder u_dut (.mclk(mclk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .host_word(host_word), .host_ready(host_ready), .mac_beat(mac_beat),
    .mac_ready(mac_ready), .irq(irq));
  txc_host_model u_host (.mclk(mclk), .host_ready(host_ready), .host_word(host_word));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ==========================================
  // compare and finish
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // sink stalls every other cycle
  always @(posedge mclk) mac_ready <= ~mac_ready & ~rst;
  always @(posedge mclk) begin
    if (!rst && mac_beat.valid && mac_ready) begin
      eb = exp_q.size() > 0 ? exp_q.pop_front() : '0;
      check({mac_beat.be, mac_beat.buf_end, mac_beat.last_seg, mac_beat.data
        & {{8{mac_beat.be[3]}}, {8{mac_beat.be[2]}}, {8{mac_beat.be[1]}}, {8{mac_beat.be[0]}}}},
        {eb.be, eb.buf_end, eb.last_seg, eb.data});
    end
  end
  task automatic expect_buf(input int off, input int sz, input logic ls);
    txc_beat_s b;
    for (int w = off / 4; w <= (off + sz - 1) / 4; w++) begin
      b = '0;
      b.valid = 1'b1;
      for (int j = 0; j < 4; j++)
        if (4*w+j >= off && 4*w+j < off+sz) begin
          b.be[j] = 1'b1;
          b.data[8*j +: 8] = 8'(4*w+j);
        end
      b.buf_end = w == (off + sz - 1) / 4;
      b.last_seg = ls;
      exp_q.push_back(b);
    end
  endtask
  // ==========================================
  // register bus master
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    bit got;
    got = 0;
    @(posedge mclk);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid) begin
        axi_req.bready <= 1'b0;
        got = 1;
        check(axi_rsp.bresp, er);
      end
    end while (!got);
  endtask
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic [1:0] er);
    bit got;
    got = 0;
    @(posedge mclk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid) begin
        axi_req.rready <= 1'b0;
        got = 1;
        check({axi_rsp.rresp, axi_rsp.rdata & m}, {er, e});
      end
    end while (!got);
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs;
    axi_rd(REG_INT_STS, 32'hffff_ffff, 32'h0, RESP_OKAY);
    axi_wr(REG_INT_EN, 32'h3, RESP_OKAY);
    axi_rd(REG_INT_EN, 32'hffff_ffff, 32'h3, RESP_OKAY);
    axi_wr(32'h10, 32'h1, RESP_SLVERR);
    axi_rd(32'h10, 32'hffff_ffff, 32'h0, RESP_SLVERR);
  endtask
  task automatic t_bufs;
    int offs[5] = '{0, 5, 31, 2, 3};
    int szs[5] = '{1, 4, 40, 61, 5};
    logic [1:0] als[5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
    for (int i = 0; i < 5; i++) begin
      expect_buf(offs[i], szs[i], 1'b1);
      u_host.send_buf(1'b0, als[i], 5'(offs[i]), 11'(szs[i]), 1'b1, 1'b1, 11'(szs[i]));
      axi_rd(REG_DEC_STATE, 32'hf, 32'h1, RESP_OKAY);
      check(irq, 1'b0);
    end
  endtask
  task automatic t_events;
    expect_buf(9, 7, 1'b0);
    u_host.send_buf(1'b1, ALIGN_32, 5'd9, 11'd7, 1'b1, 1'b0, 11'd13);
    repeat (2) @(posedge mclk);
    check(irq, 1'b1);
    axi_wr(REG_INT_CLR, 32'h1, RESP_OKAY);
    axi_wr(REG_INT_EN, 32'h2, RESP_OKAY);
    check(irq, 1'b0);
    expect_buf(0, 6, 1'b1);
    u_host.send_buf(1'b1, ALIGN_16, 5'd0, 11'd6, 1'b0, 1'b1, 11'd13);
    axi_rd(REG_INT_STS, 32'h3, 32'h1, RESP_OKAY);
    check(irq, 1'b0);
    // length matches here, so only the reserved code can raise the error
    expect_buf(1, 3, 1'b1);
    u_host.send_buf(1'b0, 2'h3, 5'd1, 11'd3, 1'b1, 1'b1, 11'd3);
    axi_rd(REG_INT_STS, 32'h3, 32'h3, RESP_OKAY);
    check(irq, 1'b1);
    axi_wr(REG_INT_CLR, 32'h3, RESP_OKAY);
    check(irq, 1'b0);
    // legal alignment, summed size one short of the length
    expect_buf(0, 4, 1'b1);
    u_host.send_buf(1'b0, ALIGN_4, 5'd0, 11'd4, 1'b1, 1'b1, 11'd5);
    axi_rd(REG_INT_STS, 32'h3, 32'h2, RESP_OKAY);
    check(irq, 1'b1);
  endtask
  // read answer left waiting: data must stand until rready
  task automatic t_slow_rd;
    @(posedge mclk);
    axi_req.araddr <= REG_INT_EN;
    axi_req.arvalid <= 1'b1;
    do @(posedge mclk); while (axi_rsp.arready !== 1'b1);
    axi_req.arvalid <= 1'b0;
    repeat (3) @(posedge mclk);
    axi_req.rready <= 1'b1;
    do @(posedge mclk); while (axi_rsp.rvalid !== 1'b1);
    axi_req.rready <= 1'b0;
    check({axi_rsp.rresp, axi_rsp.rdata}, {RESP_OKAY, 32'h3});
  endtask
  initial begin
    rst = 1'b1;
    axi_req = '0;
    n_fail = 0;
    checked = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_slow_rd();
    t_bufs();
    t_events();
    repeat (20) @(posedge mclk);
    check(exp_q.size(), 0);
    tally_and_finish();
  end
  initial begin
    #100us;
    n_fail++;
    tally_and_finish();
  end
endmodule
